// file: fsg_guard.v
`timescale 1ns/100ps
`include "fsg_defines.vh"

// How it works
// - Flash is organised in 512-byte pages; a page is the smallest erase unit.
// - Erase covers whole pages only; writes may be a byte or a word.
// - A flash write into the region now executing is refused.
// - Code region writes are allowed only from code in the loader region.
// - Data region writes allowed from loader or code region; data region programs nothing.
// - Permitted flash programming halts the CPU; EEPROM programming does not.
// - Loader and code region sizes come from two fuses, 512 bytes per unit.
// - Loader from start to loader end; code to code end; rest is data.
// - Loader fuse zero makes the whole flash the loader region.
// - Code fuse zero with loader fuse nonzero: code region runs to flash end.
// - Code fuse not above loader fuse: no code region, data from loader end.
// - A boundary beyond the flash end (one past the last address) falls back to the fuse default.
// - Loader read protect blocks reads and execution of the loader region.
// - Read protect is set only from loader code and acts after leaving it.
// - Code and data write protect bits block further updates of their region.
// - EEPROM is 256 bytes, erased in aligned 1..32 byte blocks, written per byte.
// - An EEPROM erase-and-write of one byte is one combined operation.
// - Flash appears in data space in 32 KB blocks chosen by a window select.
module fsg_guard
#(
  parameter BUSY_CYCLES = `FSG_BUSY_CYCLES
)
(
  input wire i_mclk,
  input wire i_arst_n,
  input wire i_ce,
  input wire [`FSG_FUSE_W-1:0] i_loader_size_fuse,
  input wire [`FSG_FUSE_W-1:0] i_code_size_fuse,
  input wire [`FSG_ADDR_W-1:0] i_exec_addr,
  input wire i_op_req,
  input wire [`FSG_OP_W-1:0] i_op,
  input wire [`FSG_ADDR_W-1:0] i_target_addr,
  input wire i_word_write,
  input wire [`FSG_EE_LOG_W-1:0] i_ee_block_log,
  input wire [`FSG_PAGE_LOG_W-1:0] i_page_count_log,
  input wire i_read_req,
  input wire [`FSG_ADDR_W-1:0] i_read_addr,
  input wire i_set_loader_rp,
  input wire i_set_code_wp,
  input wire i_set_data_wp,
  input wire [`FSG_WIN_SEL_W-1:0] i_flash_window_select,
  input wire [`FSG_WIN_SHIFT-1:0] i_data_space_offset,
  output wire o_halt_cpu,
  output reg o_prog_start,
  output reg o_prog_is_flash,
  output reg [`FSG_ADDR_W-1:0] o_prog_addr,
  output reg [`FSG_ADDR_W-1:0] o_prog_len,
  output reg o_prog_erase,
  output reg o_prog_write,
  output reg o_refused,
  output wire o_read_blocked,
  output wire o_exec_blocked,
  output reg [`FSG_REG_W-1:0] o_exec_region,
  output reg [`FSG_ADDR_W:0] o_loader_end_boundary,
  output reg [`FSG_ADDR_W:0] o_code_end_boundary,
  output reg o_app_code_region_present,
  output reg o_app_data_region_present,
  output wire [`FSG_ADDR_W-1:0] o_window_addr,
  output wire o_loader_read_protect,
  output wire o_code_region_write_protect,
  output wire o_data_region_write_protect
);

  // One-hot states of the stall sequencer
  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;
  // Flash end is one past the last byte, so it needs the extra boundary bit
  localparam [`FSG_ADDR_W:0] FLASH_END_X = `FSG_FLASH_BYTES;
  // Page size held at address width so the erase length shift keeps its bits
  localparam [`FSG_ADDR_W-1:0] PAGE_LEN = `FSG_PAGE_BYTES;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [3:0] busy_cnt;
  reg [3:0] next_busy_cnt;
  reg was_in_loader;
  reg rp_armed;
  reg [`FSG_ADDR_W:0] boot_b;
  reg [`FSG_ADDR_W:0] code_b;
  reg [`FSG_FUSE_W-1:0] lf;
  reg [`FSG_FUSE_W-1:0] cf;
  reg [`FSG_REG_W-1:0] tgt_region;
  reg allowed;
  reg is_flash_op;
  reg is_ee_op;
  reg [`FSG_ADDR_W-1:0] next_len;
  reg [`FSG_ADDR_W-1:0] next_addr;
  wire rp_bit;

  // Fuse units scale by the page size into a byte boundary
  function [`FSG_ADDR_W:0] fsg_units_to_bytes;
    input [`FSG_FUSE_W-1:0] units;
    begin
      fsg_units_to_bytes = {{(`FSG_ADDR_W+1-`FSG_FUSE_W){1'b0}}, units} << `FSG_PAGE_SHIFT;
    end
  endfunction

  // Region of an address given the two boundaries; used for exec, target and read
  function [`FSG_REG_W-1:0] fsg_region_of;
    input [`FSG_ADDR_W-1:0] addr;
    input [`FSG_ADDR_W:0] bnd_loader;
    input [`FSG_ADDR_W:0] bnd_code;
    begin
      if ({1'b0, addr} < bnd_loader)
        fsg_region_of = `FSG_REG_LOADER;
      else if ({1'b0, addr} < bnd_code)
        fsg_region_of = `FSG_REG_CODE;
      else
        fsg_region_of = `FSG_REG_DATA;
    end
  endfunction

  // Byte address inside the EEPROM, with a mask for block alignment
  function [`FSG_ADDR_W-1:0] fsg_ee_addr;
    input [`FSG_ADDR_W-1:0] addr;
    input [`FSG_EE_ADDR_W-1:0] mask;
    begin
      fsg_ee_addr = {{(`FSG_ADDR_W-`FSG_EE_ADDR_W){1'b0}}, addr[`FSG_EE_ADDR_W-1:0] & mask};
    end
  endfunction

  // Operations that clear cells before or instead of writing
  function fsg_op_erases;
    input [`FSG_OP_W-1:0] op;
    begin
      fsg_op_erases = (op == `FSG_OP_FL_ERASE) || (op == `FSG_OP_EE_ERASE) ||
        (op == `FSG_OP_EE_ERWR);
    end
  endfunction

  // Operations that program new data
  function fsg_op_writes;
    input [`FSG_OP_W-1:0] op;
    begin
      fsg_op_writes = (op == `FSG_OP_FL_WRITE) || (op == `FSG_OP_EE_WRITE) ||
        (op == `FSG_OP_EE_ERWR);
    end
  endfunction

  // Boundary calculation; out-of-range fuses fall back to defaults
  always @*
  begin
    lf = i_loader_size_fuse;
    cf = i_code_size_fuse;
    if (fsg_units_to_bytes(lf) > FLASH_END_X)
      lf = `FSG_LOADER_FUSE_DEF;
    if (fsg_units_to_bytes(cf) > FLASH_END_X)
      cf = `FSG_CODE_FUSE_DEF;
    // A rejected fuse reads as its default, so it then takes the zero-fuse paths
    if (lf == {`FSG_FUSE_W{1'b0}})
    begin
      boot_b = FLASH_END_X;
      code_b = FLASH_END_X;
    end
    else if (cf == {`FSG_FUSE_W{1'b0}})
    begin
      boot_b = fsg_units_to_bytes(lf);
      code_b = FLASH_END_X;
    end
    else if (cf <= lf)
    begin
      boot_b = fsg_units_to_bytes(lf);
      code_b = boot_b;
    end
    else
    begin
      boot_b = fsg_units_to_bytes(lf);
      code_b = fsg_units_to_bytes(cf);
    end
  end

  // Boundaries and region flags are registered so they glitch-free feed outputs
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_loader_end_boundary <= {(`FSG_ADDR_W+1){1'b0}};
      o_code_end_boundary <= {(`FSG_ADDR_W+1){1'b0}};
      o_app_code_region_present <= 1'b0;
      o_app_data_region_present <= 1'b0;
      o_exec_region <= `FSG_REG_LOADER;
    end
    else if (i_ce)
    begin
      o_loader_end_boundary <= boot_b;
      o_code_end_boundary <= code_b;
      o_app_code_region_present <= (code_b > boot_b);
      o_app_data_region_present <= (code_b < FLASH_END_X);
      o_exec_region <= fsg_region_of(i_exec_addr, boot_b, code_b);
    end
  end

  // Read protect may only be requested from loader code; it arms on leaving
  assign rp_bit = o_loader_read_protect;

  fsg_prot_reg u_prot
  (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_set_loader_rp(i_set_loader_rp && (o_exec_region == `FSG_REG_LOADER)),
    .i_set_code_wp(i_set_code_wp),
    .i_set_data_wp(i_set_data_wp),
    .o_loader_rp(o_loader_read_protect),
    .o_code_wp(o_code_region_write_protect),
    .o_data_wp(o_data_region_write_protect)
  );

  // Protection arms once execution has been outside the loader with the bit set
  // Arming lags the registered region change by two edges; reads stay open that much longer
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rp_armed <= 1'b0;
      was_in_loader <= 1'b1;
    end
    else if (i_ce)
    begin
      was_in_loader <= (o_exec_region == `FSG_REG_LOADER);
      if (rp_bit && !was_in_loader)
        rp_armed <= 1'b1;
    end
  end

  assign o_read_blocked = rp_armed && i_read_req &&
    (fsg_region_of(i_read_addr, o_loader_end_boundary, o_code_end_boundary)
      == `FSG_REG_LOADER);
  assign o_exec_blocked = rp_armed && (o_exec_region == `FSG_REG_LOADER);

  // Data space window: selected 32 KB block plus offset
  assign o_window_addr = {i_flash_window_select, i_data_space_offset};

  // Permission decision for the current request
  always @*
  begin
    is_flash_op = (i_op == `FSG_OP_FL_WRITE) || (i_op == `FSG_OP_FL_ERASE);
    is_ee_op = (i_op == `FSG_OP_EE_WRITE) || (i_op == `FSG_OP_EE_ERASE) ||
      (i_op == `FSG_OP_EE_ERWR);
    tgt_region = fsg_region_of(i_target_addr, o_loader_end_boundary, o_code_end_boundary);
    allowed = 1'b0;
    if (is_flash_op)
    begin
      if (tgt_region == o_exec_region)
        allowed = 1'b0;
      else if (tgt_region == `FSG_REG_CODE)
        allowed = (o_exec_region == `FSG_REG_LOADER) && !o_code_region_write_protect;
      else if (tgt_region == `FSG_REG_DATA)
        allowed = (o_exec_region != `FSG_REG_DATA) && !o_data_region_write_protect;
      else
        allowed = 1'b0;
    end
    // EEPROM follows the same source limits but never halts the CPU
    else if (is_ee_op)
      allowed = (o_exec_region != `FSG_REG_DATA);
    // Length and aligned start of the affected area
    next_len = {{(`FSG_ADDR_W-1){1'b0}}, 1'b1};
    next_addr = i_target_addr;
    case (i_op)
      `FSG_OP_FL_ERASE:
      begin
        next_len = PAGE_LEN << i_page_count_log;
        next_addr = i_target_addr & ~(next_len - 16'h0001);
      end
      `FSG_OP_FL_WRITE:
      begin
        next_len = i_word_write ? 16'h0002 : 16'h0001;
        next_addr = i_word_write ? {i_target_addr[`FSG_ADDR_W-1:1], 1'b0} : i_target_addr;
      end
      `FSG_OP_EE_ERASE:
      begin
        next_len = 16'h0001 << i_ee_block_log;
        next_addr = fsg_ee_addr(i_target_addr, ~(next_len[`FSG_EE_ADDR_W-1:0] - 8'h01));
      end
      default:
        next_addr = is_ee_op ? fsg_ee_addr(i_target_addr, {`FSG_EE_ADDR_W{1'b1}}) :
          i_target_addr;
    endcase
    // Sizes beyond the largest block or page group are refused, not clipped
    if ((i_op == `FSG_OP_EE_ERASE) && (i_ee_block_log > `FSG_EE_MAX_BLOCK_LOG))
      allowed = 1'b0;
    if ((i_op == `FSG_OP_FL_ERASE) && (i_page_count_log > `FSG_MAX_PAGES_LOG))
      allowed = 1'b0;
  end

  // Halt only while a flash operation is under way
  // A low clock enable freezes the counter too, so the stall stretches with it
  always @*
  begin
    next_state = state;
    next_busy_cnt = busy_cnt;
    case (state)
      ST_IDLE:
        if (i_op_req && allowed && is_flash_op)
        begin
          next_state = ST_BUSY;
          next_busy_cnt = BUSY_CYCLES[3:0];
        end
      ST_BUSY:
        if (busy_cnt <= 4'h1)
          next_state = ST_IDLE;
        else
          next_busy_cnt = busy_cnt - 4'h1;
      default:
        next_state = ST_IDLE;
    endcase
  end

  assign o_halt_cpu = (state == ST_BUSY);

  // Issue accepted operations; refused ones only raise a pulse
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= ST_IDLE;
      busy_cnt <= 4'h0;
      o_prog_start <= 1'b0;
      o_prog_is_flash <= 1'b0;
      o_prog_addr <= {`FSG_ADDR_W{1'b0}};
      o_prog_len <= {`FSG_ADDR_W{1'b0}};
      o_prog_erase <= 1'b0;
      o_prog_write <= 1'b0;
      o_refused <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      busy_cnt <= next_busy_cnt;
      o_prog_start <= 1'b0;
      o_refused <= 1'b0;
      // Unused operation codes fall through with neither start nor refusal
      if (i_op_req && (state == ST_IDLE) && (is_flash_op || is_ee_op))
      begin
        if (allowed)
        begin
          o_prog_start <= 1'b1;
          o_prog_is_flash <= is_flash_op;
          o_prog_addr <= next_addr;
          o_prog_len <= next_len;
          o_prog_erase <= fsg_op_erases(i_op);
          o_prog_write <= fsg_op_writes(i_op);
        end
        else
          o_refused <= 1'b1;
      end
    end
  end

endmodule

// file: fsg_defines.vh
`ifndef FSG_DEFINES_VH
`define FSG_DEFINES_VH

// Flash geometry
`define FSG_PAGE_BYTES 512
`define FSG_PAGE_SHIFT 9
`define FSG_FLASH_BYTES 65536
`define FSG_ADDR_W 16
`define FSG_FUSE_W 8
`define FSG_WIN_BYTES 32768
`define FSG_WIN_SHIFT 15
`define FSG_WIN_SEL_W 1
// Default size fuse values used when a computed boundary is out of range
`define FSG_LOADER_FUSE_DEF 8'h00
`define FSG_CODE_FUSE_DEF 8'h00
// EEPROM geometry
`define FSG_EE_BYTES 256
`define FSG_EE_ADDR_W 8
`define FSG_EE_MAX_BLOCK_LOG 3'h5
`define FSG_EE_LOG_W 3
// Operation codes on i_op
`define FSG_OP_W 3
`define FSG_OP_NONE 3'h0
`define FSG_OP_FL_WRITE 3'h1
`define FSG_OP_FL_ERASE 3'h2
`define FSG_OP_EE_WRITE 3'h3
`define FSG_OP_EE_ERASE 3'h4
`define FSG_OP_EE_ERWR 3'h5
// Region codes
`define FSG_REG_W 2
`define FSG_REG_LOADER 2'h0
`define FSG_REG_CODE 2'h1
`define FSG_REG_DATA 2'h2
// Multi-page erase limit, as log2 of page count
`define FSG_MAX_PAGES_LOG 3'h5
`define FSG_PAGE_LOG_W 3
`define FSG_PAGE_IDX_W 7
`define FSG_BUSY_W 4
`define FSG_BUSY_CYCLES 4'h8

`endif

// file: fsg_prot_reg.v
`timescale 1ns/100ps
`include "fsg_defines.vh"

// Protection bit holder: three sticky bits that only reset clears
module fsg_prot_reg
(
  input wire i_mclk,
  input wire i_arst_n,
  input wire i_ce,
  input wire i_set_loader_rp,
  input wire i_set_code_wp,
  input wire i_set_data_wp,
  output reg o_loader_rp,
  output reg o_code_wp,
  output reg o_data_wp
);

  // Bits can only be set; a cleared state needs a reset
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_loader_rp <= 1'b0;
      o_code_wp <= 1'b0;
      o_data_wp <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_set_loader_rp)
        o_loader_rp <= 1'b1;
      if (i_set_code_wp)
        o_code_wp <= 1'b1;
      if (i_set_data_wp)
        o_data_wp <= 1'b1;
    end
  end

endmodule

// file: fsg_guard_checker.sv
`timescale 1ns/100ps
module fsg_guard_checker
(
  input wire i_mclk,
  input wire i_arst_n,
  input wire i_ce,
  input wire [7:0] i_loader_size_fuse,
  input wire i_op_req,
  input wire [2:0] i_op,
  input wire [15:0] i_target_addr,
  input wire i_word_write,
  input wire o_halt_cpu,
  input wire o_prog_start,
  input wire o_prog_is_flash,
  input wire [15:0] o_prog_addr,
  input wire [15:0] o_prog_len,
  input wire o_refused,
  input wire [1:0] o_exec_region,
  input wire [16:0] o_loader_end_boundary,
  input wire [16:0] o_code_end_boundary,
  input wire o_app_code_region_present,
  input wire o_code_region_write_protect
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // Request taken, flash kind, and region of the target
  wire take = i_ce && i_op_req && !o_halt_cpu && i_op != 3'h0 && i_op < 3'h6;
  wire fl = i_op == 3'h1 || i_op == 3'h2;
  wire [16:0] ta = {1'b0, i_target_addr};
  wire [1:0] tr = (ta < o_loader_end_boundary) ? 2'h0 :
    (o_app_code_region_present && ta < o_code_end_boundary) ? 2'h1 : 2'h2;
  // Busy window of a permitted flash operation
  sequence s_busy;
    o_halt_cpu[*8] ##1 !o_halt_cpu;
  endsequence
  property p_halt_len;
    $rose(o_halt_cpu) |-> s_busy;
  endproperty
  a_halt_len: assert property (p_halt_len) else $error("halt length wrong");
  property p_ee_run;
    o_prog_start && !o_prog_is_flash |-> !o_halt_cpu;
  endproperty
  a_ee_run: assert property (p_ee_run) else $error("eeprom op halted cpu");
  property p_quiet;
    o_refused |-> !o_halt_cpu && !o_prog_start;
  endproperty
  a_quiet: assert property (p_quiet) else $error("refusal not silent");
  property p_same;
    take && fl && tr == o_exec_region |=> o_refused;
  endproperty
  a_same: assert property (p_same) else $error("own region written");
  property p_code_src;
    take && fl && tr == 2'h1 && o_exec_region != 2'h0 |=> o_refused;
  endproperty
  a_code_src: assert property (p_code_src) else $error("code write not from loader");
  property p_data_src;
    take && o_exec_region == 2'h2 |=> o_refused;
  endproperty
  a_data_src: assert property (p_data_src) else $error("data code programmed");
  property p_code_wp;
    take && fl && tr == 2'h1 && o_code_region_write_protect |=> o_refused;
  endproperty
  a_code_wp: assert property (p_code_wp) else $error("protected code written");
  property p_word;
    take && i_op == 3'h1 && i_word_write |=>
      o_refused || (o_prog_len == 16'h0002 && !o_prog_addr[0]);
  endproperty
  a_word: assert property (p_word) else $error("word write shape wrong");
  property p_loader_zero;
    i_ce && i_loader_size_fuse == 8'h00 && $stable(i_loader_size_fuse) |=>
      o_loader_end_boundary == 17'h10000 && !o_app_code_region_present;
  endproperty
  a_loader_zero: assert property (p_loader_zero) else $error("zero fuse map wrong");
  property p_loader_end;
    i_ce && i_loader_size_fuse != 8'h00 && i_loader_size_fuse <= 8'h80 &&
      $stable(i_loader_size_fuse) |=>
      o_loader_end_boundary == {$past(i_loader_size_fuse), 9'h000};
  endproperty
  a_loader_end: assert property (p_loader_end) else $error("loader end wrong");
endmodule

bind fsg_guard fsg_guard_checker u_chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
  .i_ce(i_ce), .i_loader_size_fuse(i_loader_size_fuse), .i_op_req(i_op_req),
  .i_op(i_op), .i_target_addr(i_target_addr), .i_word_write(i_word_write),
  .o_halt_cpu(o_halt_cpu), .o_prog_start(o_prog_start),
  .o_prog_is_flash(o_prog_is_flash), .o_prog_addr(o_prog_addr),
  .o_prog_len(o_prog_len), .o_refused(o_refused), .o_exec_region(o_exec_region),
  .o_loader_end_boundary(o_loader_end_boundary),
  .o_code_end_boundary(o_code_end_boundary),
  .o_app_code_region_present(o_app_code_region_present),
  .o_code_region_write_protect(o_code_region_write_protect));

// file: fsg_cpu_model.sv
`timescale 1ns/100ps
module fsg_cpu_model
(
  input wire i_mclk,
  input wire i_arst_n,
  input wire i_halt,
  output wire [15:0] o_exec_addr
);
  reg [15:0] base = 16'h0100;
  reg [3:0] pc;
  // Tight loop of 32 bytes so fetches never stray into the next region
  assign o_exec_addr = base + {11'h000, pc, 1'b0};
  // Fetch advances only while the flash is not busy
  always @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
      pc <= 4'h0;
    else if (!i_halt)
      pc <= pc + 4'h1;
  // Branch into another region
  task jump(input [15:0] a);
    base = a;
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, v); end end
module testbench;
  reg i_mclk = 1'b0, i_arst_n = 1'b0, i_op_req = 1'b0, i_word_write = 1'b0;
  reg i_read_req = 1'b1, i_set_loader_rp = 1'b0, i_set_code_wp = 1'b0;
  reg i_set_data_wp = 1'b0, i_flash_window_select = 1'b1, i_ce = 1'b1;
  reg [7:0] i_loader_size_fuse = 8'h04, i_code_size_fuse = 8'h08;
  reg [2:0] i_op = 3'h0, i_ee_block_log = 3'h5, i_page_count_log = 3'h2;
  reg [15:0] i_target_addr = 16'h0000, i_read_addr = 16'h0010;
  reg [14:0] i_data_space_offset = 15'h0123;
  wire [15:0] i_exec_addr, o_prog_addr, o_prog_len, o_window_addr;
  wire [16:0] o_loader_end_boundary, o_code_end_boundary;
  wire o_halt_cpu, o_prog_start, o_prog_is_flash, o_refused, o_read_blocked;
  wire o_exec_blocked, o_app_code_region_present, o_app_data_region_present;
  wire o_loader_read_protect, o_prog_erase, o_prog_write, o_code_region_write_protect;
  wire o_data_region_write_protect;
  wire [1:0] o_exec_region;
  integer failures = 0, cmp_count = 0, cyc = 0;
  fsg_guard u_fsg_guard (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_loader_size_fuse(i_loader_size_fuse), .i_code_size_fuse(i_code_size_fuse),
    .i_exec_addr(i_exec_addr), .i_op_req(i_op_req), .i_op(i_op),
    .i_target_addr(i_target_addr), .i_word_write(i_word_write),
    .i_ee_block_log(i_ee_block_log), .i_page_count_log(i_page_count_log),
    .i_read_req(i_read_req), .i_read_addr(i_read_addr),
    .i_set_loader_rp(i_set_loader_rp), .i_set_code_wp(i_set_code_wp),
    .i_set_data_wp(i_set_data_wp), .i_flash_window_select(i_flash_window_select),
    .i_data_space_offset(i_data_space_offset), .o_halt_cpu(o_halt_cpu),
    .o_prog_start(o_prog_start), .o_prog_is_flash(o_prog_is_flash),
    .o_prog_addr(o_prog_addr), .o_prog_len(o_prog_len), .o_prog_erase(o_prog_erase),
    .o_prog_write(o_prog_write), .o_refused(o_refused), .o_read_blocked(o_read_blocked),
    .o_exec_blocked(o_exec_blocked), .o_exec_region(o_exec_region),
    .o_loader_end_boundary(o_loader_end_boundary),
    .o_code_end_boundary(o_code_end_boundary),
    .o_app_code_region_present(o_app_code_region_present),
    .o_app_data_region_present(o_app_data_region_present),
    .o_window_addr(o_window_addr), .o_loader_read_protect(o_loader_read_protect),
    .o_code_region_write_protect(o_code_region_write_protect),
    .o_data_region_write_protect(o_data_region_write_protect));
  fsg_cpu_model u_fsg_cpu_model (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_halt(o_halt_cpu), .o_exec_addr(i_exec_addr));
  // Clock and hang guard; the ceiling is nearly thirty times the expected run
  initial forever #25 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      final_report;
    end
  end
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task tick;
    begin
      @(posedge i_mclk);
      #1;
    end
  endtask
  // Branch, then let the registered region catch up
  task go(input [15:0] a);
    begin
      u_fsg_cpu_model.jump(a);
      repeat (2) tick;
    end
  endtask
  // One request; the answer lands one edge later, then the stall is timed
  task op(input [2:0] c, input [15:0] a, input ok, input hlt);
    integer n;
    begin
      tick;
      i_op = c;
      i_target_addr = a;
      i_op_req = 1'b1;
      tick;
      i_op_req = 1'b0;
      `CHK("start", ok, o_prog_start)
      `CHK("refused", !ok, o_refused)
      `CHK("halt", hlt, o_halt_cpu)
      n = 0;
      while (o_halt_cpu === 1'b1 && n < 20)
      begin
        tick;
        n = n + 1;
      end
      `CHK("stall", hlt ? 8 : 0, n)
    end
  endtask
  // Fuse pair and the map it must give
  task fz(input [7:0] l, input [7:0] c, input [16:0] le, input cp, input dp);
    begin
      i_loader_size_fuse = l;
      i_code_size_fuse = c;
      repeat (2) tick;
      `CHK("lend", le, o_loader_end_boundary)
      `CHK("code", cp, o_app_code_region_present)
      `CHK("data", dp, o_app_data_region_present)
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (5) tick;
    i_arst_n = 1'b1;
    repeat (2) tick;
    fz(8'h04, 8'h08, 17'h00800, 1'b1, 1'b1);
    `CHK("cend", 17'h01000, o_code_end_boundary)
    `CHK("win", 16'h8123, o_window_addr)
    op(3'h1, 16'h0200, 0, 0);
    op(3'h1, 16'h0A00, 1, 1);
    op(3'h1, 16'h1000, 1, 1);
    op(3'h4, 16'h00FF, 1, 0);
    `CHK("eeaddr", 16'h00E0, o_prog_addr)
    `CHK("eelen", 16'h0020, o_prog_len)
    `CHK("eeerase", 1'b1, o_prog_erase)
    `CHK("eewrite", 1'b0, o_prog_write)
    `CHK("eeflash", 1'b0, o_prog_is_flash)
    op(3'h3, 16'h0010, 1, 0);
    op(3'h5, 16'h0011, 1, 0);
    `CHK("ererase", 1'b1, o_prog_erase)
    `CHK("erwrite", 1'b1, o_prog_write)
    i_word_write = 1'b1;
    op(3'h1, 16'h1003, 1, 1);
    `CHK("waddr", 16'h1002, o_prog_addr)
    `CHK("wlen", 16'h0002, o_prog_len)
    `CHK("wflash", 1'b1, o_prog_is_flash)
    op(3'h2, 16'h19FF, 1, 1);
    `CHK("paddr", 16'h1800, o_prog_addr)
    `CHK("plen", 16'h0800, o_prog_len)
    $display("test loader source done");
    go(16'h0900);
    `CHK("region", 2'h1, o_exec_region)
    op(3'h1, 16'h0A00, 0, 0);
    op(3'h1, 16'h0200, 0, 0);
    op(3'h1, 16'h1000, 1, 1);
    op(3'h3, 16'h0010, 1, 0);
    go(16'h2000);
    `CHK("region", 2'h2, o_exec_region)
    op(3'h1, 16'h1000, 0, 0);
    op(3'h3, 16'h0010, 0, 0);
    $display("test code and data source done");
    go(16'h0100);
    i_set_code_wp = 1'b1;
    i_set_data_wp = 1'b1;
    i_set_loader_rp = 1'b1;
    tick;
    i_set_code_wp = 1'b0;
    i_set_data_wp = 1'b0;
    i_set_loader_rp = 1'b0;
    `CHK("cwp", 1'b1, o_code_region_write_protect)
    `CHK("dwp", 1'b1, o_data_region_write_protect)
    op(3'h1, 16'h0A00, 0, 0);
    op(3'h1, 16'h1000, 0, 0);
    `CHK("rpbit", 1'b1, o_loader_read_protect)
    `CHK("rdearly", 1'b0, o_read_blocked)
    `CHK("exearly", 1'b0, o_exec_blocked)
    go(16'h0900);
    // Arming needs two edges after the region change is registered; go gave one
    tick;
    `CHK("rdlate", 1'b1, o_read_blocked)
    go(16'h0100);
    `CHK("exblk", 1'b1, o_exec_blocked)
    $display("test protection done");
    fz(8'h00, 8'h08, 17'h10000, 1'b0, 1'b0);
    fz(8'h04, 8'h00, 17'h00800, 1'b1, 1'b0);
    fz(8'h04, 8'h02, 17'h00800, 1'b0, 1'b1);
    fz(8'h04, 8'hC8, 17'h00800, 1'b1, 1'b0);
    // Clock enable low must hold the old map despite a new fuse value
    i_ce = 1'b0;
    i_loader_size_fuse = 8'h02;
    repeat (2) tick;
    `CHK("frozen", 17'h00800, o_loader_end_boundary)
    i_ce = 1'b1;
    fz(8'h02, 8'hC8, 17'h00400, 1'b1, 1'b0);
    $display("test fuse map done");
    final_report;
  end
endmodule
